//--- core/digital_io_submodule.sv
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dio_counter_defs.svh"

// Overview of operation
// - sixteen inputs, eight outputs, two counter channels sharing pins.
// - every input and output drives its own indicator; lit when active.
// - edge interrupts only configurable on the first ten inputs.
// - rising and falling edge interrupt enables are independent per input.
// - diagnostic interrupt only reports a lost hardware interrupt.
// - input filter delay chosen per group of four inputs.
// - setting 0.1 ms kept; any other setting uses 0.35 ms.
// - counter pins: 0.0-0.2 ch0, 0.3-0.5 ch1, latches 1.4 and 1.5.
// - output bits 0 and 1 are compare outputs of channels 0 and 1.
// - counter inputs stay readable; writes to counter-owned outputs ignored.
// - count pulses correctly to 5 kHz on both channels with the short filter setting.
// - each counter exposes its count as one 32-bit word.
// - without configuration inputs sit at addresses 124 and 125.
// - counts at 768 and 772; 776 and 780 reserved.
// - output byte at 124; output words 768 to 780 reserved.
// - configured start addresses replace the defaults when present.
// - continuous, single and periodic count modes per channel.
// - single/periodic reload start value at end value counting up, end value at 1 counting down.
// - internal gate from hardware and software gate; hardware part disableable.
// - hardware gate opens on rising, closes on falling gate input edge.
// - software gate follows the level of the software gate bit.
// - count readable via count output port and input address.
// - rising latch input captures the count into a readable holding register.
// - direction input sense may be inverted per channel.
// - stop mode freezes and resumes; cancel mode restarts from load value.
module digital_io_submodule
    import dio_counter_pkg::*;
#(
    parameter int unsigned FILT_SHORT = `FILT_SHORT_CYC,
    parameter int unsigned FILT_LONG  = `FILT_LONG_CYC
) (
    input  wire logic                      clk_i,
    input  wire logic                      sys_rst_i,
    input  wire dio_counter_pkg::bus_req_t bus_i,
    output logic [31:0]                    rdata_o,
    input  wire logic [15:0]               din_i,
    output logic [7:0]                     dout_o,
    output logic [15:0]                    din_led_o,
    output logic [7:0]                     dout_led_o,
    output logic                           hw_irq_o,
    output logic                           diag_irq_o,
    output logic [63:0]                    count_value_output_o
);
    import dio_counter_pkg::*;

    // debounce counter width; it must hold the long filter count at the
    // nominal clock, a narrower counter would wrap and never settle
    localparam int CW = 16;

    // two-flop synchronisers for the field inputs
    // field pins arrive with no relation to clk_i, so nothing but the
    // second synchroniser stage may be read by the filter logic
    logic [15:0] sync1_r;
    logic [15:0] sync2_r;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync1_r <= 16'h0000;
            sync2_r <= 16'h0000;
        end else begin
            sync1_r <= din_i;
            sync2_r <= sync1_r;
        end
    end

    // control registers
    // software-visible state; all of it returns to the defaults on
    // reset, so an unconfigured device answers at the default map
    logic [15:0]  irq_rise_r;
    logic [15:0]  irq_fall_r;
    logic [3:0]   filt_sel_r;
    logic [7:0]   out_r;
    logic [1:0]   software_gate_r;
    logic [6:0]   mode_r   [2];
    logic [31:0]  limit_r  [2];
    logic [31:0]  load_r   [2];
    logic [11:0]  base_in_r;
    logic [11:0]  base_out_r;
    logic [11:0]  base_cnt_r;

    // filtered inputs, one debounce counter per channel
    logic [15:0] filt_r;
    logic [CW-1:0] fcnt_r [16];
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_filt
            logic [CW-1:0] lim;
            // a level must stand for the whole delay before it is taken;
            // any bounce back to the old level restarts the count
            // short time only for the short setting, long otherwise
            assign lim = filt_sel_r[gi/4] ? CW'(FILT_SHORT) : CW'(FILT_LONG);
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    fcnt_r[gi] <= '0;
                    filt_r[gi] <= 1'b0;
                end else if (sync2_r[gi] == filt_r[gi]) begin
                    fcnt_r[gi] <= '0;
                end else if (fcnt_r[gi] >= lim - CW'(1)) begin
                    fcnt_r[gi] <= '0;
                    filt_r[gi] <= sync2_r[gi];
                end else begin
                    fcnt_r[gi] <= fcnt_r[gi] + CW'(1);
                end
            end
        end
    endgenerate

    // one-cycle delay of the filtered levels gives clean edge pulses
    // for interrupts, counting, gating and latching alike
    logic [15:0] filt_d_r;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) filt_d_r <= 16'h0000;
        else           filt_d_r <= filt_r;
    end
    wire logic [15:0] rise = filt_r & ~filt_d_r;
    wire logic [15:0] fall = ~filt_r & filt_d_r;

    // edge interrupts, first ten inputs only
    // pending bits are cleared by writing ones to the status word;
    // bit 16 clears the lost flag; an event on a still pending bit
    // is what the diagnostic flag reports
    logic [15:0] irq_pend_r;
    logic        lost_r;
    logic [15:0] irq_ev;
    logic [15:0] irq_clr;
    assign irq_ev = ((rise & irq_rise_r) | (fall & irq_fall_r))
                  & 16'h03FF;
    assign irq_clr = (bus_i.wr && bus_i.addr == `ADDR_IRQ_STAT) ?
                     bus_i.wdata[15:0] : 16'h0000;
    // set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_pend_r <= 16'h0000;
            lost_r     <= 1'b0;
        end else begin
            irq_pend_r <= (irq_pend_r & ~irq_clr) | irq_ev;
            if ((irq_ev & irq_pend_r & ~irq_clr) != 16'h0000)
                lost_r <= 1'b1;
            else if (bus_i.wr && bus_i.addr == `ADDR_IRQ_STAT
                     && bus_i.wdata[16])
                lost_r <= 1'b0;
        end
    end
    assign hw_irq_o   = |irq_pend_r;
    assign diag_irq_o = lost_r;

    // counter channels
    // each channel steps once per filtered rising edge of its pulse
    // pin; the filter bounds the usable pulse rate, so the short
    // setting is needed for the top count frequency
    logic [31:0] cnt_r   [2];
    logic [31:0] latch_r [2];
    logic [1:0]  hardware_gate_r;
    logic [1:0]  cmp_out;
    logic [1:0]  igate;
    logic [1:0]  gate_d_r;
    logic [1:0]  done_r;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cnt
            cnt_pins_t p;
            logic      dir_up;
            logic      step;
            count_mode_t md;
            assign p.pulse = filt_r[3*gi];
            assign p.dir   = filt_r[3*gi+1];
            assign p.gate  = filt_r[3*gi+2];
            assign p.latch = filt_r[12+gi];
            assign md      = count_mode_t'(mode_r[gi][1:0]);
            assign dir_up  = p.dir ^ mode_r[gi][`MODE_DIRINV_BIT];
            assign step    = rise[3*gi] & igate[gi] & ~done_r[gi];

            // hardware gate is edge driven, not level driven
            // a gate pin already high at reset opens the gate once the filter
            // has taken its level, as the filtered level starts low
            always_ff @(posedge clk_i) begin
                if (sys_rst_i)                 hardware_gate_r[gi] <= 1'b0;
                else if (rise[3*gi+2])         hardware_gate_r[gi] <= 1'b1;
                else if (fall[3*gi+2])         hardware_gate_r[gi] <= 1'b0;
            end
            assign igate[gi] = software_gate_r[gi] &
                (hardware_gate_r[gi] | ~mode_r[gi][`MODE_HWEN_BIT]);

            always_ff @(posedge clk_i) begin
                if (sys_rst_i) gate_d_r[gi] <= 1'b0;
                else           gate_d_r[gi] <= igate[gi];
            end

            // count update; single mode reloads at the end of its range, then stops until regated in cancel mode
            // cancel mode reloads on every opening, the first one included
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    cnt_r[gi]  <= 32'h0000_0000;
                    done_r[gi] <= 1'b0;
                end else if (igate[gi] && !gate_d_r[gi]
                             && !mode_r[gi][`MODE_STOP_BIT]) begin
                    cnt_r[gi]  <= load_r[gi];
                    done_r[gi] <= 1'b0;
                end else if (step) begin
                    unique case (md)
                        MODE_CONTINUOUS:
                            cnt_r[gi] <= dir_up ? cnt_r[gi] + 32'h1
                                                : cnt_r[gi] - 32'h1;
                        default: begin
                            if (dir_up && cnt_r[gi] + 32'h1 >= limit_r[gi])
                            begin
                                cnt_r[gi]  <= load_r[gi];
                                done_r[gi] <= (md == MODE_SINGLE);
                            end else if (!dir_up && cnt_r[gi] <= 32'h1)
                            begin
                                cnt_r[gi]  <= limit_r[gi];
                                done_r[gi] <= (md == MODE_SINGLE);
                            end else begin
                                cnt_r[gi] <= dir_up ? cnt_r[gi] + 32'h1
                                                    : cnt_r[gi] - 32'h1;
                            end
                        end
                    endcase
                end
            end

            always_ff @(posedge clk_i) begin
                if (sys_rst_i)         latch_r[gi] <= 32'h0000_0000;
                else if (rise[12+gi])  latch_r[gi] <= cnt_r[gi];
            end
            // compare: set while the signed count is at or above the limit
            assign cmp_out[gi] = mode_r[gi][`MODE_CMP_BIT] &
                                 ($signed(cnt_r[gi]) >= $signed(limit_r[gi]));
        end
    endgenerate
    // both counts leave on one port so the controller may sample them
    // without a bus access
    assign count_value_output_o = {cnt_r[1], cnt_r[0]};

    // register writes; the hardware owns counter-driven output bits
    wire logic [11:0] wa = bus_i.addr;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_r      <= 8'h00;
            irq_rise_r <= 16'h0000;
            irq_fall_r <= 16'h0000;
            filt_sel_r <= 4'h0;
            software_gate_r  <= 2'h0;
            base_in_r  <= `ADDR_IN_LOW;
            base_out_r <= `ADDR_OUT_BYTE;
            base_cnt_r <= `ADDR_CNT0;
        end else if (bus_i.wr) begin
            if (wa == base_out_r) out_r <= bus_i.wdata[7:0];
            if (wa == `ADDR_IRQ_RISE) irq_rise_r <= bus_i.wdata[15:0];
            if (wa == `ADDR_IRQ_FALL) irq_fall_r <= bus_i.wdata[15:0];
            if (wa == `ADDR_FILT_SEL) filt_sel_r <= bus_i.wdata[3:0];
            if (wa == `ADDR_GATE_CTRL) software_gate_r <= bus_i.wdata[1:0];
            if (wa == `ADDR_BASE_IN)  base_in_r  <= bus_i.wdata[11:0];
            if (wa == `ADDR_BASE_OUT) base_out_r <= bus_i.wdata[11:0];
            if (wa == `ADDR_BASE_CNT) base_cnt_r <= bus_i.wdata[11:0];
        end
    end

    // per-channel configuration; reserved counter words take no write
    // a new limit takes effect on the next step; a limit below the
    // present count wraps on the next up step
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cfg
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    mode_r[gi]  <= 7'h00;
                    limit_r[gi] <= `LIMIT_RESET;
                    load_r[gi]  <= 32'h0000_0000;
                end else if (bus_i.wr) begin
                    if (wa == `ADDR_CNT_MODE0 + 12'(4*gi))
                        mode_r[gi] <= bus_i.wdata[6:0];
                    if (wa == `ADDR_LIMIT0 + 12'(4*gi))
                        limit_r[gi] <= bus_i.wdata;
                    if (wa == `ADDR_LOAD0 + 12'(4*gi))
                        load_r[gi] <= bus_i.wdata;
                end
            end
        end
    endgenerate

    // outputs: compare-owned bits follow the counter, not software
    // the software value is still stored for an owned bit, so it
    // reappears on the pin once the compare function is switched off
    logic [7:0] dout;
    always_comb begin
        dout = out_r;
        if (mode_r[0][`MODE_CMP_BIT]) dout[0] = cmp_out[0];
        if (mode_r[1][`MODE_CMP_BIT]) dout[1] = cmp_out[1];
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dout_o     <= 8'h00;
            dout_led_o <= 8'h00;
            din_led_o  <= 16'h0000;
        end else begin
            dout_o     <= dout;
            dout_led_o <= dout;
            din_led_o  <= filt_r;
        end
    end

    // read path, data stands the cycle after the strobe
    // unmapped and reserved addresses fall through to zero; the word is
    // cleared outside the read cycle so stale values never linger
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (bus_i.addr == base_in_r)
            rd_nxt = {24'h0, filt_r[7:0]};
        else if (bus_i.addr == base_in_r + 12'h1)
            rd_nxt = {24'h0, filt_r[15:8]};
        else if (bus_i.addr == base_cnt_r)
            rd_nxt = cnt_r[0];
        else if (bus_i.addr == base_cnt_r + 12'h4)
            rd_nxt = cnt_r[1];
        else if (bus_i.addr == `ADDR_LATCH0) rd_nxt = latch_r[0];
        else if (bus_i.addr == `ADDR_LATCH1) rd_nxt = latch_r[1];
        else if (bus_i.addr == `ADDR_LIMIT0) rd_nxt = limit_r[0];
        else if (bus_i.addr == `ADDR_LIMIT1) rd_nxt = limit_r[1];
        else if (bus_i.addr == `ADDR_LOAD0)  rd_nxt = load_r[0];
        else if (bus_i.addr == `ADDR_LOAD1)  rd_nxt = load_r[1];
        else if (bus_i.addr == `ADDR_IRQ_STAT)
            rd_nxt = {15'h0, lost_r, irq_pend_r};
        else if (bus_i.addr == `ADDR_GATE_CTRL)
            rd_nxt = {28'h0, hardware_gate_r, software_gate_r};
        else if (bus_i.addr == `ADDR_CNT_MODE0)
            rd_nxt = {24'h0, done_r[0], mode_r[0]};
        else if (bus_i.addr == `ADDR_CNT_MODE1)
            rd_nxt = {24'h0, done_r[1], mode_r[1]};
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i)     rdata_o <= 32'h0000_0000;
        else if (bus_i.rd) rdata_o <= rd_nxt;
        else               rdata_o <= 32'h0000_0000;
    end
endmodule : digital_io_submodule
`default_nettype wire

//--- core/dio_counter_defs.svh
`ifndef DIO_COUNTER_DEFS_SVH
`define DIO_COUNTER_DEFS_SVH

// register byte addresses (default peripheral map)
`define ADDR_IN_LOW      12'h07C
`define ADDR_IN_HIGH     12'h07D
`define ADDR_OUT_BYTE    12'h07C
`define ADDR_CNT0        12'h300
`define ADDR_CNT1        12'h304
`define ADDR_RSVD_C      12'h308
`define ADDR_RSVD_D      12'h30C
// own control registers
`define ADDR_GATE_CTRL   12'h400
`define ADDR_CNT_MODE0   12'h404
`define ADDR_CNT_MODE1   12'h408
`define ADDR_LIMIT0      12'h40C
`define ADDR_LIMIT1      12'h410
`define ADDR_LOAD0       12'h414
`define ADDR_LOAD1       12'h418
`define ADDR_LATCH0      12'h41C
`define ADDR_LATCH1      12'h420
`define ADDR_IRQ_RISE    12'h424
`define ADDR_IRQ_FALL    12'h428
`define ADDR_IRQ_STAT    12'h42C
`define ADDR_FILT_SEL    12'h430
`define ADDR_BASE_IN     12'h434
`define ADDR_BASE_OUT    12'h438
`define ADDR_BASE_CNT    12'h43C

// mode register fields
`define MODE_SEL_LSB     0
`define MODE_DOWN_BIT    2
`define MODE_DIRINV_BIT  3
`define MODE_HWEN_BIT    4
`define MODE_STOP_BIT    5
`define MODE_CMP_BIT     6

// filter times in ns
`define FILT_SHORT_NS    100000
`define FILT_LONG_NS     350000
`define CLK_PERIOD_NS    10
`define FILT_SHORT_CYC   (`FILT_SHORT_NS / `CLK_PERIOD_NS)
`define FILT_LONG_CYC    (`FILT_LONG_NS / `CLK_PERIOD_NS)

`define LIMIT_RESET      32'h7FFFFFFF
`define IRQ_INPUTS       10

`endif

//--- core/dio_counter_pkg.sv
package dio_counter_pkg;
    typedef enum logic [1:0] {
        MODE_CONTINUOUS = 2'b00,
        MODE_SINGLE     = 2'b01,
        MODE_PERIODIC   = 2'b11
    } count_mode_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        logic pulse;
        logic dir;
        logic gate;
        logic latch;
    } cnt_pins_t;
endpackage : dio_counter_pkg

//--- testbench/digital_io_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "dio_counter_defs.svh"
module dio_checker
    import dio_counter_pkg::*;
(
    input wire logic                      clk_i,
    input wire logic                      sys_rst_i,
    input wire dio_counter_pkg::bus_req_t bus_i,
    input wire logic [31:0]               rdata_o,
    input wire logic [7:0]                dout_o,
    input wire logic [15:0]               din_led_o,
    input wire logic [7:0]                dout_led_o,
    input wire logic                      hw_irq_o,
    input wire logic                      diag_irq_o,
    input wire logic [63:0]               count_value_output_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // led and pin load in the same cycle; only settled outputs are compared
    property p_led_out;
        $stable(dout_o) [*2] |-> dout_led_o == dout_o;
    endproperty
    a_led_out: assert property (p_led_out) else $error("led wrong");
    property p_rsvd_rd;
        bus_i.rd && bus_i.addr inside {`ADDR_RSVD_C, `ADDR_RSVD_D}
            |=> rdata_o == 32'h0;
    endproperty
    a_rsvd_rd: assert property (p_rsvd_rd) else $error("rsvd rd");
    property p_rd_in;
        bus_i.rd && bus_i.addr == `ADDR_IN_HIGH ##1 $stable(din_led_o)
            |-> rdata_o == {24'h0, din_led_o[15:8]};
    endproperty
    a_rd_in: assert property (p_rd_in) else $error("input rd");
    property p_rd_cnt;
        bus_i.rd && bus_i.addr == `ADDR_CNT1
            ##1 $stable(count_value_output_o)
            |-> rdata_o == count_value_output_o[63:32];
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("count rd");
    property p_out_wr;
        bus_i.wr && bus_i.addr == `ADDR_OUT_BYTE
            |=> ##1 dout_o[7:2] == $past(bus_i.wdata[7:2], 2);
    endproperty
    a_out_wr: assert property (p_out_wr) else $error("out wr");
    property p_rsvd_wr;
        bus_i.wr && bus_i.addr inside {`ADDR_CNT0, `ADDR_CNT1, `ADDR_RSVD_C,
            `ADDR_RSVD_D} |=> $stable(dout_o);
    endproperty
    a_rsvd_wr: assert property (p_rsvd_wr) else $error("rsvd wr");
    // an edge on the first ten inputs must precede any new request
    property p_irq_edge;
        $rose(hw_irq_o) |-> din_led_o[9:0] != $past(din_led_o[9:0], 4);
    endproperty
    a_irq_edge: assert property (p_irq_edge) else $error("irq src");
    property p_lost;
        $rose(diag_irq_o) |-> $past(hw_irq_o);
    endproperty
    a_lost: assert property (p_lost) else $error("diag src");
    property p_gate_shut;
        bus_i.wr && bus_i.addr == `ADDR_GATE_CTRL && bus_i.wdata[0] == 1'b0
            |=> ##1 $stable(count_value_output_o[31:0]) [*2];
    endproperty
    a_gate_shut: assert property (p_gate_shut) else $error("gate");
    c_cnt_rd: cover property (bus_i.rd && bus_i.addr == `ADDR_CNT1);
    c_irq: cover property ($rose(hw_irq_o));
    c_lost: cover property ($rose(diag_irq_o));
endmodule : dio_checker
bind digital_io_submodule dio_checker u_chk (.clk_i, .sys_rst_i, .bus_i,
    .rdata_o, .dout_o, .din_led_o, .dout_led_o, .hw_irq_o, .diag_irq_o,
    .count_value_output_o);
`default_nettype wire

//--- testbench/field_pins.sv
`timescale 1ns/1ps
`default_nettype none
module field_pins (
    input  wire logic        clk_i,
    output logic      [15:0] din_o
);
    initial din_o = 16'h0000;
    // levels change just after an edge, then stand long past the filter
    task automatic put(input logic [15:0] v);
        @(posedge clk_i);
        din_o <= v;
        repeat (20) @(posedge clk_i);
    endtask : put
    task automatic set_pin(input int idx, input logic v);
        @(posedge clk_i);
        din_o[idx] <= v;
        repeat (20) @(posedge clk_i);
    endtask : set_pin
    // encoder pulses, each level held 21 cycles, well past the shortened filter
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            set_pin(idx, 1'b1);
            set_pin(idx, 1'b0);
        end
    endtask : pulse
endmodule : field_pins
`default_nettype wire

//--- testbench/digital_io_with_gated_counters_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dio_counter_defs.svh"
module digital_io_with_gated_counters_test;
    import dio_counter_pkg::*;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    bus_req_t    bus_i = '0;
    logic [31:0] rdata_o;
    logic [15:0] din_i;
    logic [7:0]  dout_o;
    logic [15:0] din_led_o;
    logic [7:0]  dout_led_o;
    logic        hw_irq_o;
    logic        diag_irq_o;
    logic [63:0] cnt;
    int          n_errors = 0;
    int          comparisons = 0;
    logic [31:0] modes [3] = '{32'h0, 32'h1, 32'h3};
    logic [31:0] exps [3] = '{32'h5, 32'h0, 32'h2};
    always #5 clk_i = ~clk_i;
    field_pins fp (.clk_i(clk_i), .din_o(din_i));
    // short filters keep pulse trains brief
    digital_io_submodule #(.FILT_SHORT(2), .FILT_LONG(5)) dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .din_i(din_i), .dout_o(dout_o),
        .din_led_o(din_led_o), .dout_led_o(dout_led_o),
        .hw_irq_o(hw_irq_o), .diag_irq_o(diag_irq_o),
        .count_value_output_o(cnt));
    task automatic end_of_test;
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one request at a time, the next only once this one is over
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        #1 check(rdata_o, exp);
    endtask : rd
    // compare logic and leds need a few cycles to follow
    task automatic out_is(input logic [7:0] exp);
        repeat (3) @(posedge clk_i);
        #1 check(dout_o, exp);
        check(dout_led_o, exp);
    endtask : out_is
    initial begin
        repeat (100000) @(posedge clk_i);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(`ADDR_RSVD_C, 32'h0);
        rd(12'h500, 32'h0);
        rd(`ADDR_LIMIT0, `LIMIT_RESET);
        fp.put(16'hC0C0);
        rd(`ADDR_IN_LOW, 32'hC0);
        rd(`ADDR_IN_HIGH, 32'hC0);
        check(din_led_o, 16'hC0C0);
        wr(`ADDR_OUT_BYTE, 32'hF3);
        out_is(8'hF3);
        wr(`ADDR_CNT0, 32'h0);
        wr(`ADDR_RSVD_D, 32'h0);
        out_is(8'hF3);
        // channel 1 counts up with a low direction pin through inversion
        fp.put(16'h0002);
        wr(`ADDR_CNT_MODE1, 32'h8);
        wr(`ADDR_GATE_CTRL, 32'h3);
        fp.pulse(0, 5);
        fp.pulse(3, 2);
        rd(`ADDR_CNT0, 32'h5);
        rd(`ADDR_CNT1, 32'h2);
        wr(`ADDR_GATE_CTRL, 32'h2);
        fp.pulse(0, 2);
        rd(`ADDR_CNT0, 32'h5);
        // hardware gate evaluated, stop mode keeps the count
        wr(`ADDR_CNT_MODE0, 32'h30);
        wr(`ADDR_GATE_CTRL, 32'h3);
        fp.pulse(0, 2);
        rd(`ADDR_CNT0, 32'h5);
        fp.set_pin(2, 1'b1);
        fp.pulse(0, 3);
        rd(`ADDR_CNT0, 32'h8);
        fp.set_pin(2, 1'b0);
        fp.pulse(0, 1);
        rd(`ADDR_CNT0, 32'h8);
        fp.set_pin(12, 1'b1);
        rd(`ADDR_LATCH0, 32'h8);
        rd(`ADDR_IN_LOW, 32'h02);
        // each mode from a fresh gate opening, end value 3
        wr(`ADDR_LIMIT0, 32'h3);
        foreach (modes[k]) begin
            wr(`ADDR_CNT_MODE0, modes[k]);
            wr(`ADDR_GATE_CTRL, 32'h2);
            wr(`ADDR_GATE_CTRL, 32'h3);
            fp.pulse(0, 5);
            rd(`ADDR_CNT0, exps[k]);
        end
        check(cnt[63:32], 32'h2);
        check(cnt[31:0], 32'h2);
        // channel 1 compare output owns bit 1
        wr(`ADDR_CNT_MODE1, 32'h48);
        out_is(8'hF1);
        wr(`ADDR_LIMIT1, 32'h2);
        out_is(8'hF3);
        wr(`ADDR_OUT_BYTE, 32'h0);
        out_is(8'h02);
        // input 12 cannot interrupt, input 6 can
        wr(`ADDR_IRQ_RISE, 32'h1040);
        fp.set_pin(12, 1'b0);
        fp.set_pin(12, 1'b1);
        check(hw_irq_o, 1'b0);
        fp.set_pin(6, 1'b1);
        check(hw_irq_o, 1'b1);
        fp.set_pin(6, 1'b0);
        check(diag_irq_o, 1'b0);
        fp.set_pin(6, 1'b1);
        check(diag_irq_o, 1'b1);
        wr(`ADDR_IRQ_STAT, 32'h10040);
        repeat (2) @(posedge clk_i);
        check({hw_irq_o, diag_irq_o}, 2'b00);
        end_of_test();
    end
endmodule : digital_io_with_gated_counters_test
`default_nettype wire
